/* File: include/owbi_pkg.sv */
// Operation
// - One command selects any of 32 levels.
// - Level code starts at full scale.
// - Code held in register; reset restores default.
// - Address byte then data byte; address compared.
// - Data bit7 ack request, 6:5 zero, 4:0 code.
// - Code maps to pseudo-logarithmic millivolt reference.
// - Bytes arrive most significant bit first.
// - Line already high needs no start interval.
// - End-of-stream interval closes each byte.
// - Bit value from two-to-one high/low ratio.
// - Bit measured falling edge to falling edge.
// - Acknowledge needs flag, address match, sixteen good bits.
// - After valid delay, pull line low briefly.
// - Serial mode needs long low inside window.
// - Chosen mode stays until shutdown.
// - Line low over 2.5 ms means shutdown.
package owbi_pkg;
  // ----------------------------------------------------------------
  // Clock and timing figures.
  // ----------------------------------------------------------------
  // Clock rate in kHz.
  localparam int CLK_KHZ = 40000;
  // End-of-stream time in ns.
  localparam int EOS_NS = 2000;
  // Serial-mode delay, low time and window in ns.
  localparam int SM_DELAY_NS = 100000;
  localparam int SM_LOW_NS = 260000;
  localparam int SM_WIN_NS = 1000000;
  // Shutdown low time in ns.
  localparam int SHDN_NS = 2500000;
  // Acknowledge valid delay and hold time in ns.
  localparam int ACK_VALID_NS = 2000;
  localparam int ACK_HOLD_NS = 512000;
  // Least times round up, longest times round down.
  localparam int EOS_CYC = (EOS_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int SM_DELAY_CYC = (SM_DELAY_NS * (CLK_KHZ / 1000) + 999)
    / 1000;
  localparam int SM_LOW_CYC = (SM_LOW_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int SM_WIN_CYC = SM_WIN_NS / 1000 * (CLK_KHZ / 1000);
  localparam int SHDN_CYC = (SHDN_NS / 1000) * (CLK_KHZ / 1000);
  localparam int ACK_VALID_CYC = ACK_VALID_NS * (CLK_KHZ / 1000) / 1000;
  localparam int ACK_HOLD_CYC = ACK_HOLD_NS / 1000 * (CLK_KHZ / 1000);
  // Width of the time counters.
  localparam int CNT_W = 17;
  // ----------------------------------------------------------------
  // Frame layout.
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int CODE_W = 5;
  localparam int MV_W = 8;
  localparam logic [7:0] DEV_ADDR = 8'h5a; // Arbitrary address value.
  localparam int ACKREQ_BIT = 7;
  localparam int SUBHI_BIT = 6;
  localparam int SUBLO_BIT = 5;
  localparam logic [4:0] CODE_FULL = 5'h1f;
  localparam logic [3:0] BITS_LAST = 4'h7;
  // Pseudo-logarithmic knee codes, step sizes and base levels.
  localparam logic [4:0] KNEE1 = 5'h0c;
  localparam logic [4:0] KNEE2 = 5'h17;
  localparam logic [7:0] MV_BASE1 = 8'h02;
  localparam logic [7:0] MV_STEP1 = 8'h03;
  localparam logic [7:0] MV_KNEE1 = 8'h26;
  localparam logic [7:0] MV_STEP2 = 8'h06;
  localparam logic [7:0] MV_KNEE2 = 8'h68;
  localparam logic [7:0] MV_STEP3 = 8'h0c;
  // Mode selection states.
  typedef enum logic [3:0] {
    OWBI_OFF = 4'b0001,
    OWBI_DETECT = 4'b0010,
    OWBI_PWM = 4'b0100,
    OWBI_SERIAL = 4'b1000
  } owbi_mode_t;
endpackage

/* File: design/owbi_level_map.sv */
`timescale 1ns/1ps
// Maps a level code onto its reference in millivolts.
module owbi_level_map
  import owbi_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [4:0] code,
  output logic [7:0] ref_mv
);
  // ----------------------------------------------------------------
  // State and next value.
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] mv;
  } owbi_map_t;
  owbi_map_t st;
  owbi_map_t next_st;
  logic [7:0] c8;

  // Three linear segments with growing step size.
  always_comb
  begin
    c8 = {3'b000, code};
    next_st = st;
    if (code == '0)
      next_st.mv = '0;
    else if (code <= KNEE1)
      next_st.mv = 8'(MV_BASE1 + MV_STEP1 * c8);
    else if (code <= KNEE2)
      next_st.mv = 8'(MV_KNEE1 + MV_STEP2 * (c8 - {3'b000, KNEE1}));
    else
      next_st.mv = 8'(MV_KNEE2 + MV_STEP3 * (c8 - {3'b000, KNEE2}));
  end

  // Register the reference.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  assign ref_mv = st.mv;
endmodule

/* File: design/owbi_receiver.sv */
`timescale 1ns/1ps
// Single-wire brightness receiver with mode detection and acknowledge.
module owbi_receiver
  import owbi_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  output logic [4:0] level_code,
  output logic [7:0] feedback_reference,
  output logic serial_mode,
  output logic pwm_mode,
  output logic shutdown,
  output logic cmd_ok,
  output logic cmd_err
);
  // ----------------------------------------------------------------
  // Block state.
  // ----------------------------------------------------------------
  typedef struct packed
  {
    owbi_mode_t mode;     // Current mode selection.
    logic line_q;         // Line level one cycle ago.
    logic [CNT_W-1:0] low_cnt;  // Cycles line has been low.
    logic [CNT_W-1:0] high_cnt; // Cycles line has been high.
    logic [CNT_W-1:0] win_cnt;  // Cycles since detect window opened.
    logic [CNT_W-1:0] t_high;   // High part of the current bit.
    logic [CNT_W-1:0] t_lowpart; // Low part of the current bit.
    logic in_bit;         // A bit period is open.
    logic [7:0] shreg;    // Byte being assembled.
    logic [3:0] nbits;    // Bits in the current byte.
    logic byte_no;        // Zero for address, one for data.
    logic addr_ok;        // Address byte matched.
    logic bad;            // A ratio or framing fault seen.
    logic [4:0] code;     // Stored level code.
    logic ack_pend;       // Acknowledge waiting for valid delay.
    logic [CNT_W-1:0] ack_cnt; // Acknowledge timer.
    logic ack_on;         // Pull-down active.
    logic ok;             // Command accepted pulse.
    logic err;            // Command discarded pulse.
  } owbi_state_t;
  owbi_state_t st;
  owbi_state_t next_st;
  logic fall;
  logic rise;
  logic [7:0] nbyte;
  logic bit_one;
  logic bit_zero;
  logic [CNT_W-1:0] t_low;

  // Edges of the line; the line is taken as synchronous.
  assign fall = st.line_q && !line_in;
  assign rise = !st.line_q && line_in;

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  // Decides mode, decodes bits, frames bytes and times acknowledge.
  always_comb
  begin
    next_st = st;
    next_st.line_q = line_in;
    next_st.ok = 1'b0;
    next_st.err = 1'b0;
    t_low = st.t_lowpart;
    // Bit value from high and low parts of the period; a spare bit
    // keeps the doubled time from wrapping on a long level.
    bit_one = ({1'b0, st.t_high} >= {t_low, 1'b0});
    bit_zero = ({1'b0, t_low} >= {st.t_high, 1'b0});
    nbyte = {st.shreg[6:0], bit_one};
    // Run time counters, saturating.
    if (line_in)
    begin
      next_st.low_cnt = '0;
      if (st.high_cnt != '1)
        next_st.high_cnt = st.high_cnt + 1'b1;
    end
    else
    begin
      next_st.high_cnt = '0;
      if (st.low_cnt != '1)
        next_st.low_cnt = st.low_cnt + 1'b1;
    end
    if (st.win_cnt != '1)
      next_st.win_cnt = st.win_cnt + 1'b1;
    // Track the high part, and keep the low part at the rising edge,
    // because the low counter clears as soon as the line is high.
    if (line_in)
      next_st.t_high = next_st.high_cnt;
    if (rise)
      next_st.t_lowpart = st.low_cnt;
    // Mode selection.
    unique case (st.mode)
      OWBI_OFF:
      begin
        // First rising edge enables and opens the window.
        if (rise)
        begin
          next_st.mode = OWBI_DETECT;
          next_st.win_cnt = '0;
        end
      end
      OWBI_DETECT:
      begin
        if (!line_in && st.low_cnt >= CNT_W'(SM_LOW_CYC)
            && st.win_cnt >= CNT_W'(SM_DELAY_CYC + SM_LOW_CYC))
          next_st.mode = OWBI_SERIAL;
        else if (st.win_cnt >= CNT_W'(SM_WIN_CYC))
          next_st.mode = OWBI_PWM;
      end
      OWBI_PWM:
        next_st.mode = OWBI_PWM;
      OWBI_SERIAL:
        next_st.mode = OWBI_SERIAL;
    endcase
    // Long low ends the mode and returns to shutdown.
    if (!line_in && !st.ack_on && st.low_cnt >= CNT_W'(SHDN_CYC))
    begin
      next_st.mode = OWBI_OFF;
      next_st.in_bit = 1'b0;
      next_st.nbits = '0;
      next_st.byte_no = 1'b0;
    end
    // Serial reception.
    if (st.mode == OWBI_SERIAL && !st.ack_on && !st.ack_pend)
    begin
      // A falling edge opens a bit, and closes the previous one.
      if (fall)
      begin
        if (st.in_bit)
        begin
          next_st.shreg = nbyte;
          next_st.nbits = st.nbits + 1'b1;
          if (!bit_one && !bit_zero)
            next_st.bad = 1'b1;
        end
        next_st.in_bit = 1'b1;
        next_st.t_high = '0;
      end
      // High for end-of-stream closes the byte with its last bit.
      else if (st.in_bit && line_in
               && st.high_cnt == CNT_W'(EOS_CYC))
      begin
        next_st.in_bit = 1'b0;
        next_st.nbits = '0;
        if (st.nbits != BITS_LAST || !bit_one && !bit_zero)
          next_st.bad = 1'b1;
        if (!st.byte_no)
        begin
          next_st.byte_no = 1'b1;
          next_st.addr_ok = (nbyte == DEV_ADDR);
        end
        else
        begin
          next_st.byte_no = 1'b0;
          next_st.bad = 1'b0;
          if (st.addr_ok && !st.bad && st.nbits == BITS_LAST
              && !nbyte[SUBHI_BIT] && !nbyte[SUBLO_BIT]
              && (bit_one || bit_zero))
          begin
            next_st.code = nbyte[CODE_W-1:0];
            next_st.ok = 1'b1;
            // Acknowledge only on request and full success.
            if (nbyte[ACKREQ_BIT])
            begin
              next_st.ack_pend = 1'b1;
              next_st.ack_cnt = '0;
            end
          end
          else
            next_st.err = 1'b1;
        end
      end
    end
    // Acknowledge timing after the last rising edge.
    if (st.ack_pend)
    begin
      next_st.ack_cnt = st.ack_cnt + 1'b1;
      if (st.ack_cnt + CNT_W'(EOS_CYC) >= CNT_W'(ACK_VALID_CYC))
      begin
        next_st.ack_pend = 1'b0;
        next_st.ack_on = 1'b1;
        next_st.ack_cnt = '0;
      end
    end
    else if (st.ack_on)
    begin
      next_st.ack_cnt = st.ack_cnt + 1'b1;
      if (st.ack_cnt >= CNT_W'(ACK_HOLD_CYC - 1))
      begin
        next_st.ack_on = 1'b0;
        next_st.ack_cnt = '0;
        next_st.low_cnt = '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  // Reset restores the full-scale code and shutdown.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.mode <= OWBI_OFF;
      st.code <= CODE_FULL;
    end
    else if (clk_en)
      st <= next_st;
  end

  // Level map to millivolts.
  owbi_level_map i_owbi_level_map (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .code(st.code),
    .ref_mv(feedback_reference)
  );

  // ----------------------------------------------------------------
  // Outputs from flip-flops, except line_out tied low and the mode flags decoded from the mode register.
  // ----------------------------------------------------------------
  assign line_out = 1'b0;
  assign line_oe = st.ack_on;
  assign level_code = st.code;
  assign serial_mode = (st.mode == OWBI_SERIAL);
  assign pwm_mode = (st.mode == OWBI_PWM);
  assign shutdown = (st.mode == OWBI_OFF);
  assign cmd_ok = st.ok;
  assign cmd_err = st.err;
endmodule

/* File: sim/owbi_receiver_sva.sv */
`timescale 1ns/1ps
// ----
// Port checker for the receiver.
// ----
module owbi_receiver_sva
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic line_out,
  input wire logic line_oe,
  input wire logic [4:0] level_code,
  input wire logic [7:0] feedback_reference,
  input wire logic serial_mode,
  input wire logic pwm_mode,
  input wire logic shutdown,
  input wire logic cmd_ok,
  input wire logic cmd_err
);
  // Cycles the pull-down has stood so far.
  logic [14:0] oe_cnt;
  // Count while the pull-down is on, clear once it lets go.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      oe_cnt <= 15'h0000;
    else
      oe_cnt <= line_oe ? oe_cnt + 15'h0001 : 15'h0000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_out_low; !line_out; endproperty
  a_out_low: assert property (p_out_low) else $error("drives high");
  property p_oe_max; line_oe |-> oe_cnt < 15'h5000; endproperty
  a_oe_max: assert property (p_oe_max) else $error("ack long");
  property p_oe_len; $fell(line_oe) |-> oe_cnt == 15'h5000; endproperty
  a_oe_len: assert property (p_oe_len) else $error("ack short");
  property p_err_noack; cmd_err |=> (!line_oe) [*3]; endproperty
  a_err_noack: assert property (p_err_noack) else $error("bad ack");
  property p_pulse; cmd_ok || cmd_err |=> !cmd_ok && !cmd_err; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_code_src;
    $changed(level_code) |-> cmd_ok || $past(cmd_ok) || $past(cmd_ok, 2);
  endproperty
  a_code_src: assert property (p_code_src) else $error("code moved");
  property p_ref_follow;
    $changed(level_code) && clk_en |=> $changed(feedback_reference);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("stale");
  property p_pwm_stay; pwm_mode |=> pwm_mode || shutdown; endproperty
  a_pwm_stay: assert property (p_pwm_stay) else $error("left pwm");
  c_ack: cover property ($rose(line_oe));
  c_err: cover property (cmd_err);
  c_pwm: cover property ($rose(pwm_mode));
endmodule
bind owbi_receiver owbi_receiver_sva i_owbi_receiver_sva (.clk, .arst_n,
  .clk_en, .line_out, .line_oe, .level_code, .feedback_reference,
  .serial_mode, .pwm_mode, .shutdown, .cmd_ok, .cmd_err);

/* File: sim/owbi_host_model.sv */
`timescale 1ns/1ps
// ----
// Open-drain master on the enable line.
// ----
module owbi_host_model
(
  input wire logic clk,
  output logic host_low
);
  // Hold a level n cycles, ending 2 ns after an edge.
  task automatic drv(input logic lvl, input int n);
    host_low = !lvl; // Pulls low or lets go, never drives high.
    repeat (n) @(posedge clk);
    #2;
  endtask
  // A byte MSB first; k slows it, bit bad gets an even ratio.
  task automatic send_byte(input logic [7:0] b, input int k, bad);
    int lo, hi;
    for (int i = 7; i >= 0; i--)
    begin
      lo = i == bad ? 20 : b[i] ? 10 * k : 170 * k;
      hi = i == bad ? 20 : b[i] ? 30 * k : 10 * k;
      drv(1'b0, lo);
      drv(1'b1, hi);
    end
    // Closing high that doubles as the next start; then left released.
    drv(1'b1, 100);
  endtask
endmodule

/* File: sim/tb_one_wire_brightness_interface.sv */
`timescale 1ns/1ps
// ----
// Bench for the single-wire receiver.
// ----
module tb_one_wire_brightness_interface;
  logic clk, arst_n, clk_en, line_in, line_out, line_oe, host_low;
  logic serial_mode, pwm_mode, shutdown, cmd_ok, cmd_err;
  logic [4:0] level_code, last_code;
  logic [7:0] feedback_reference;
  // Pending outcomes: stored flag over the expected code.
  logic [5:0] exp_q[$];
  // Own device address, taken from the shared constants.
  localparam logic [7:0] OWN_ADDR = owbi_pkg::DEV_ADDR;
  int fail_count, comparisons, seed;
  // Pull-up wire, low while either side pulls.
  assign line_in = !(host_low || (line_oe && !line_out));
  owbi_receiver i_owbi_receiver (.clk, .arst_n, .clk_en, .line_in,
    .line_out, .line_oe, .level_code, .feedback_reference, .serial_mode,
    .pwm_mode, .shutdown, .cmd_ok, .cmd_err);
  owbi_host_model i_owbi_host_model (.clk, .host_low);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Reference in mV for a code, three step sizes.
  function automatic logic [7:0] mv(input logic [4:0] c);
    if (c == 5'h00) return 8'h00;
    if (c <= 5'h0c) return 8'h02 + 8'h03 * c;
    if (c <= 5'h17) return 8'h06 * c - 8'h22;
    return 8'h0c * c - 8'hac;
  endfunction
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Reset with the line low, then raise it for hi cycles.
  task automatic boot(input int hi);
    arst_n = 1'b0;
    i_owbi_host_model.drv(1'b0, 10);
    check(shutdown, 8'h01);
    arst_n = 1'b1;
    last_code = 5'h1f;
    i_owbi_host_model.drv(1'b1, hi);
  endtask
  // Note the outcome, then send address and data bytes.
  task automatic cmd(input logic [7:0] a, d, input int k, bad);
    logic ok;
    ok = a == OWN_ADDR && d[6:5] == 2'b00 && bad == 8;
    if (ok) last_code = d[4:0];
    exp_q.push_back({ok, last_code});
    i_owbi_host_model.send_byte(a, k, 8);
    i_owbi_host_model.send_byte(d, k, bad);
  endtask
  // Compare each command outcome with the oldest note.
  initial
  begin
    logic [5:0] n;
    forever
    begin
      @(negedge clk);
      if (cmd_ok === 1'b1 || cmd_err === 1'b1)
      begin
        check(8'(exp_q.size()), 8'h01);
        n = exp_q.pop_front();
        check(cmd_ok, n[5]);
        repeat (3) @(negedge clk);
        check(level_code, n[4:0]);
        check(feedback_reference, mv(n[4:0]));
      end
    end
  end
  // Cut a hang short.
  initial
  begin
    #3250000;
    fail_count++;
    $display("[FAIL] %0t run hung", $time);
    end_sim();
  end
  initial
  begin
    logic [4:0] tbl [5];
    seed = 32'h9eef;
    fail_count = 0;
    comparisons = 0;
    clk_en = 1'b1;
    tbl = '{5'h0c, 5'h0d, 5'h17, 5'h18, 5'h00};
    tbl[4] = 5'($random(seed));
    boot(4100);
    i_owbi_host_model.drv(1'b0, 10500);
    i_owbi_host_model.drv(1'b1, 100);
    check(serial_mode, 8'h01);
    check(feedback_reference, 8'hc8);
    check(shutdown, 8'h00);
    $display("test mode entry done");
    cmd(OWN_ADDR ^ 8'h01, 8'h85, 1, 8);
    cmd(OWN_ADDR, 8'h25, 2, 8);
    cmd(OWN_ADDR, 8'h05, 1, 3);
    check(line_oe, 8'h00);
    $display("test discard done");
    for (int i = 0; i < 5; i++)
      cmd(OWN_ADDR, {3'b000, tbl[i]}, 1 + i % 2, 8);
    $display("test levels done");
    cmd(OWN_ADDR, 8'h81, 1, 8);
    check(line_oe, 8'h01);
    check(line_out, 8'h00);
    check(line_in, 8'h00);
    for (int n = 0; n < 21000 && line_oe !== 1'b0; n++)
      @(posedge clk);
    #2;
    check(line_oe, 8'h00);
    $display("test acknowledge done");
    boot(40100); // A steady high is full duty into PWM mode.
    check(level_code, 8'h1f);
    check(pwm_mode, 8'h01);
    i_owbi_host_model.drv(1'b0, 10500);
    i_owbi_host_model.drv(1'b1, 100);
    check(pwm_mode, 8'h01);
    check(serial_mode, 8'h00);
    $display("test pwm done");
    end_sim();
  end
endmodule
